// ### include/spfs_defs.svh
// spfs_defs.svh: register offsets, field positions, reset values, timing
// assumes: included by package and design files by bare name
`ifndef SPFS_DEFS_SVH
`define SPFS_DEFS_SVH
// register byte offsets on the avalon slave
`define SPFS_REG_CTRL 4'h0
`define SPFS_REG_STAT 4'h4
`define SPFS_REG_LOCK 4'h8
`define SPFS_REG_FUSE 4'hC
`define SPFS_REG_IRQS 5'h10
`define SPFS_REG_IRQM 5'h14
// control register fields
`define SPFS_CTRL_GO 0
`define SPFS_CTRL_ERASE 1
`define SPFS_CTRL_CLRBUSY 2
`define SPFS_CTRL_PAGE_LSB 8
// status register fields
`define SPFS_STAT_BUSY 0
`define SPFS_STAT_HALT 1
`define SPFS_STAT_ACTIVE 2
// interrupt status fields
`define SPFS_IRQ_DONE 0
`define SPFS_IRQ_DENIED 1
// reset values: lock bits unprogrammed (1), fuses give largest boot area
`define SPFS_LOCK_RESET 4'hF
`define SPFS_FUSE_RESET 2'h0
// flash geometry: 128 pages, halting section is the top 16 pages
`define SPFS_PAGE_W 7
`define SPFS_HALTING_SECTION_FIRST 7'h70
// programming time in ns and cycles at 10 ns
`define SPFS_PROG_NS 4000
`define SPFS_CLK_NS 10
`define SPFS_PROG_CYC ((`SPFS_PROG_NS + `SPFS_CLK_NS - 1) / `SPFS_CLK_NS)
`endif

// ### include/spfs_pkg.sv
// spfs_pkg: types shared by the flash section controller files
// assumes: spfs_defs.svh on the include path
`include "spfs_defs.svh"
package spfs_pkg;
    typedef logic [`SPFS_PAGE_W-1:0] spfs_page_t;
    // avalon-mm request bundle
    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [31:0] writedata;
    } spfs_bus_req_t;
    // core-side store request bundle
    typedef struct packed {
        logic valid;
        logic erase;
        logic from_boot;
        spfs_page_t page;
    } spfs_store_req_t;
    typedef enum logic [1:0] {
        SPFS_IDLE = 2'b00,
        SPFS_PROG = 2'b01,
        SPFS_DONE = 2'b10
    } spfs_state_t;
endpackage

// ### logic/spfs_perm.sv
// spfs_perm: decides whether a store may program a page and where it lands
// assumes: lock and fuse values held stable by the caller
`timescale 1ns/1ns
`include "spfs_defs.svh"
module spfs_perm (
    input wire spfs_pkg::spfs_page_t page_i, // target page
    input wire logic from_boot_i, // store executes from boot section
    input wire logic [3:0] lock_i, // {boot pair, app pair}
    input wire logic [1:0] fuse_i, // boot size fuses
    output logic allow_o, // store permitted
    output logic halt_sec_o, // page in halting section
    output logic in_boot_o // page in boot section
);
    import spfs_pkg::*;
    wire [`SPFS_PAGE_W-1:0] boot_first;
    // boot size: 16, 8, 4, 2 pages, always inside the halting section
    assign boot_first = 7'h7F - ((7'h10 >> fuse_i) - 7'h01);
    assign in_boot_o = page_i >= boot_first;
    assign halt_sec_o = page_i >= `SPFS_HALTING_SECTION_FIRST;
    // app pair low bit clear (modes 10, 00) blocks writes to application;
    // boot pair likewise guards boot pages, each pair independent
    wire app_wr_block = ~lock_i[0];
    wire boot_wr_block = ~lock_i[2];
    // only boot-resident code may start programming, any page reachable
    assign allow_o = from_boot_i &&
        (in_boot_o ? !boot_wr_block : !app_wr_block);
endmodule // spfs_perm

// ### logic/spfs_ctrl.sv
// spfs_ctrl: self-programming flash section controller with avalon slave
// assumes: one 100 MHz clock, synchronous reset, core gives store requests
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "spfs_defs.svh"
module spfs_ctrl (
    input wire logic clock_i, // 100 MHz system clock
    input wire logic reset_i, // synchronous active-high reset
    input wire logic enable_i, // clock enable, freezes all state
    input wire logic chip_erase_i, // full chip erase pulse
    input wire spfs_pkg::spfs_store_req_t store_i, // core store request
    input wire logic lpm_from_boot_i, // core load executes from boot
    input wire spfs_pkg::spfs_page_t lpm_page_i, // page of core load
    input wire logic [4:0] avs_address_i, // byte address
    input wire logic avs_read_i, // read strobe
    input wire logic avs_write_i, // write strobe
    input wire logic [31:0] avs_writedata_i, // write data
    output logic [31:0] avs_readdata_o, // read data
    output logic avs_waitrequest_o, // stall
    output logic core_halt_o, // stall the core
    output logic rww_block_o, // concurrent section unreadable
    output logic lpm_deny_o, // load blocked by lock
    output logic irq_o // level interrupt
);
    import spfs_pkg::*;

    spfs_state_t state;
    spfs_state_t next_state;
    logic [15:0] timer;
    logic [3:0] lock;
    logic [1:0] fuse;
    logic busy;
    logic op_halt;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic ack;
    spfs_store_req_t reg_req;

    // bus request bundle
    spfs_bus_req_t bus;
    assign bus = '{read: avs_read_i, write: avs_write_i,
                   address: avs_address_i, writedata: avs_writedata_i};

    // address decode
    wire sel_ctrl = bus.address == 5'(`SPFS_REG_CTRL);
    wire sel_stat = bus.address == 5'(`SPFS_REG_STAT);
    wire sel_lock = bus.address == 5'(`SPFS_REG_LOCK);
    wire sel_fuse = bus.address == 5'(`SPFS_REG_FUSE);
    wire sel_irqs = bus.address == `SPFS_REG_IRQS;
    wire sel_irqm = bus.address == `SPFS_REG_IRQM;
    wire req = (bus.read | bus.write) & ~ack;
    wire wr = bus.write & ~ack & enable_i;
    wire rd = bus.read & ~ack & enable_i;

    // register-driven store: treated as executing from the boot section
    wire ctrl_go = wr & sel_ctrl & bus.writedata[`SPFS_CTRL_GO];
    wire ctrl_clr = wr & sel_ctrl & bus.writedata[`SPFS_CTRL_CLRBUSY];
    spfs_store_req_t cur;
    assign cur = store_i.valid ? store_i : reg_req;

    // permission and section lookup
    logic allow;
    logic halt_sec;
    logic in_boot;
    spfs_perm u_perm (
        .page_i(cur.page),
        .from_boot_i(cur.from_boot),
        .lock_i(lock),
        .fuse_i(fuse),
        .allow_o(allow),
        .halt_sec_o(halt_sec),
        .in_boot_o(in_boot)
    );
    // load check reuses the lookup for the core's read page
    logic lpm_in_boot;
    spfs_perm u_lpm (
        .page_i(lpm_page_i),
        .from_boot_i(1'b1),
        .lock_i(lock),
        .fuse_i(fuse),
        .allow_o(),
        .halt_sec_o(),
        .in_boot_o(lpm_in_boot)
    );
    // pair modes 00 and 01 block boot-side loads of application pages;
    // this only gates loads, not fetch, so normal execution is untouched
    wire next_lpm_deny = lpm_from_boot_i & ~lpm_in_boot &
        ~lock[1];

    wire start = (state == SPFS_IDLE) & cur.valid;
    wire go_ok = start & allow;
    wire go_bad = start & ~allow;
    wire prog_end = (state == SPFS_PROG) &&
        (timer == 16'(`SPFS_PROG_CYC - 1));

    // sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            SPFS_IDLE: if (go_ok) next_state = SPFS_PROG;
            SPFS_PROG: if (prog_end) next_state = SPFS_DONE;
            SPFS_DONE: next_state = SPFS_IDLE;
            default: next_state = SPFS_IDLE;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state <= SPFS_IDLE;
            timer <= 16'h0000;
            op_halt <= 1'b0;
        end else if (enable_i) begin
            state <= next_state;
            timer <= (state == SPFS_PROG) ? timer + 16'h0001 : 16'h0000;
            if (go_ok) op_halt <= halt_sec;
        end
    end

    // queued register store, dropped once the sequencer takes it
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            reg_req <= '0;
        end else if (enable_i) begin
            if (ctrl_go) begin
                reg_req <= '{valid: 1'b1,
                    erase: bus.writedata[`SPFS_CTRL_ERASE],
                    from_boot: 1'b1,
                    page: bus.writedata[`SPFS_CTRL_PAGE_LSB +: `SPFS_PAGE_W]};
            end else if (start & ~store_i.valid) begin
                reg_req <= '0;
            end
        end
    end

    // busy flag: set at start wins over a software clear in same cycle;
    // the output mirror takes the same next value so the two never part
    wire next_busy = (go_ok & ~halt_sec) |
        (busy & ~(ctrl_clr & (state == SPFS_IDLE)));
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            busy <= 1'b0;
        end else if (enable_i) begin
            busy <= next_busy;
        end
    end

    // lock bits only move toward programmed; chip erase restores them
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            lock <= `SPFS_LOCK_RESET;
            fuse <= `SPFS_FUSE_RESET;
        end else if (enable_i) begin
            if (chip_erase_i) lock <= `SPFS_LOCK_RESET;
            else if (wr & sel_lock)
                lock <= lock & bus.writedata[3:0];
            if (wr & sel_fuse) fuse <= bus.writedata[1:0];
        end
    end

    // sticky events; a set in the clearing read cycle survives
    wire [1:0] ev = {go_bad, prog_end};
    wire [1:0] clr = (rd & sel_irqs) ? irq_stat : 2'b00;
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            irq_stat <= 2'h0;
            irq_mask <= 2'h0;
        end else if (enable_i) begin
            irq_stat <= (irq_stat & ~clr) | ev;
            if (wr & sel_irqm) irq_mask <= bus.writedata[1:0];
        end
    end

    // read mux
    wire [31:0] rdata =
        sel_ctrl ? {16'h0000, 1'b0, reg_req.page, 6'h00,
                    reg_req.erase, reg_req.valid} :
        sel_stat ? {29'h0, state == SPFS_PROG, core_halt_o, busy} :
        sel_lock ? {28'h0, lock} :
        sel_fuse ? {30'h0, fuse} :
        sel_irqs ? {30'h0, irq_stat} :
        sel_irqm ? {30'h0, irq_mask} : 32'h0000_0000;

    // one wait cycle then acknowledge; unmapped reads give zero
    // waitrequest has its own flop so no gate sits after it
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ack <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
        end else if (enable_i) begin
            ack <= req;
            avs_waitrequest_o <= ~req;
            if (rd) avs_readdata_o <= rdata;
        end
    end

    // registered outputs
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            core_halt_o <= 1'b0;
            rww_block_o <= 1'b0;
            lpm_deny_o <= 1'b0;
            irq_o <= 1'b0;
        end else if (enable_i) begin
            core_halt_o <= (next_state == SPFS_PROG) &
                (go_ok ? halt_sec : op_halt);
            rww_block_o <= next_busy;
            lpm_deny_o <= next_lpm_deny;
            irq_o <= |((((irq_stat & ~clr) | ev)) & irq_mask);
        end
    end

    // assertions
    property p_halt_whole;
        @(posedge clock_i) disable iff (reset_i)
        enable_i && go_ok && halt_sec |=> core_halt_o [*8];
    endproperty
    a_halt_whole: assert property (p_halt_whole)
        else $error("core not halted during halting section program");
    property p_no_halt_rww;
        @(posedge clock_i) disable iff (reset_i)
        state == SPFS_PROG && !op_halt |-> !core_halt_o;
    endproperty
    a_no_halt_rww: assert property (p_no_halt_rww)
        else $error("core halted during concurrent section program");
    property p_app_deny;
        @(posedge clock_i) disable iff (reset_i)
        enable_i && start && !cur.from_boot |=> state == SPFS_IDLE;
    endproperty
    a_app_deny: assert property (p_app_deny)
        else $error("store from application started programming");
    property p_busy_set;
        @(posedge clock_i) disable iff (reset_i)
        enable_i && go_ok && !halt_sec |=> busy && rww_block_o;
    endproperty
    a_busy_set: assert property (p_busy_set)
        else $error("busy not set on concurrent section start");
    property p_busy_prog;
        @(posedge clock_i) disable iff (reset_i)
        state == SPFS_PROG && !op_halt |-> busy;
    endproperty
    a_busy_prog: assert property (p_busy_prog)
        else $error("busy low while concurrent section programs");
    property p_lock_mono;
        @(posedge clock_i) disable iff (reset_i)
        !$past(chip_erase_i) |-> (lock & ~$past(lock)) == 4'h0;
    endproperty
    a_lock_mono: assert property (p_lock_mono)
        else $error("lock bit returned to unprogrammed without erase");
    property p_app_wr;
        @(posedge clock_i) disable iff (reset_i)
        enable_i && start && !lock[0] && cur.page < 7'h70
            |=> state == SPFS_IDLE;
    endproperty
    a_app_wr: assert property (p_app_wr)
        else $error("write to locked application section started");
    sequence s_read_wait;
        avs_read_i && avs_waitrequest_o;
    endsequence
    property p_bus_ack;
        @(posedge clock_i) disable iff (reset_i)
        s_read_wait ##0 enable_i |=> !avs_waitrequest_o;
    endproperty
    a_bus_ack: assert property (p_bus_ack)
        else $error("read not answered in one cycle");
    // section geometry, lock pairs and loads checked against the lookups; busy hold, program end and refusal events
    property p_boot_in_halt;
        @(posedge clock_i) disable iff (reset_i)
        in_boot |-> halt_sec;
    endproperty
    a_boot_in_halt: assert property (p_boot_in_halt)
        else $error("boot page outside halting section");
    property p_boot_wr;
        @(posedge clock_i) disable iff (reset_i)
        enable_i && start && in_boot && !lock[2] |=> state == SPFS_IDLE;
    endproperty
    a_boot_wr: assert property (p_boot_wr)
        else $error("write to locked boot section started");
    property p_any_page;
        @(posedge clock_i) disable iff (reset_i)
        enable_i && start && cur.from_boot &&
            (in_boot ? lock[2] : lock[0]) |=> state == SPFS_PROG;
    endproperty
    a_any_page: assert property (p_any_page)
        else $error("permitted boot store did not start");
    property p_lpm_deny;
        @(posedge clock_i) disable iff (reset_i)
        enable_i && lpm_from_boot_i && !lpm_in_boot && !lock[1]
            |=> lpm_deny_o;
    endproperty
    a_lpm_deny: assert property (p_lpm_deny)
        else $error("boot load of locked application page passed");
    property p_lpm_free;
        @(posedge clock_i) disable iff (reset_i)
        enable_i && !lpm_from_boot_i |=> !lpm_deny_o;
    endproperty
    a_lpm_free: assert property (p_lpm_free)
        else $error("load from application code denied");
    property p_busy_hold;
        @(posedge clock_i) disable iff (reset_i)
        busy && !(ctrl_clr && state == SPFS_IDLE) |=> busy && rww_block_o;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped without software clear");
    property p_halt_end;
        @(posedge clock_i) disable iff (reset_i)
        enable_i && prog_end |=> !core_halt_o && irq_stat[`SPFS_IRQ_DONE];
    endproperty
    a_halt_end: assert property (p_halt_end)
        else $error("stall or done flag wrong after program end");
    property p_deny_irq;
        @(posedge clock_i) disable iff (reset_i)
        enable_i && go_bad |=> irq_stat[`SPFS_IRQ_DENIED];
    endproperty
    a_deny_irq: assert property (p_deny_irq)
        else $error("refused store left no event");
    // concurrent programming: flag up, core running, several steps long
    sequence s_rww_go;
        enable_i && go_ok && !halt_sec;
    endsequence
    sequence s_rww_run;
        rww_block_o && !core_halt_o;
    endsequence
    property p_rww_run;
        @(posedge clock_i) disable iff (reset_i)
        s_rww_go |=> s_rww_run [*8];
    endproperty
    a_rww_run: assert property (p_rww_run)
        else $error("concurrent section program stalled the core");
endmodule // spfs_ctrl

// ### sim/spfs_core_model.sv
// spfs_core_model: behavioural processor core running boot software
// assumes: shares the clock of spfs_ctrl; the bench calls its tasks
`timescale 1ns/1ns
`include "spfs_defs.svh"
module spfs_core_model (
    input wire logic clock_i, // system clock
    input wire logic halt_i, // core stalled by the controller
    input wire logic busy_i, // concurrent section blocked
    output spfs_pkg::spfs_store_req_t store_o, // store request
    output logic lpm_from_boot_o, // load executes from boot section
    output spfs_pkg::spfs_page_t lpm_page_o // page of the load
);
    import spfs_pkg::*;
    // quiet core at time zero
    initial begin
        store_o = '0;
        lpm_from_boot_o = 1'b0;
        lpm_page_o = '0;
    end
    // one-cycle store; the bench only calls it while the controller idles
    task automatic do_store(input logic erase, input logic boot,
            input spfs_page_t page);
        @(posedge clock_i);
        store_o <= '{valid: 1'b1, erase: erase, from_boot: boot, page: page};
        @(posedge clock_i);
        // released lines show junk so nothing leans on a stale page
        store_o <= '{valid: 1'b0, erase: ~erase, from_boot: ~boot,
            page: ~page};
    endtask
    // load lines set once and left standing until the next load; interrupts are not modelled, so no vector
    // fetch can reach the concurrent section while it programs
    task automatic do_load(input logic boot, input spfs_page_t page);
        @(posedge clock_i);
        if (halt_i !== 1'b0)
            return;
        if (busy_i !== 1'b0 && page < `SPFS_HALTING_SECTION_FIRST)
            return;
        lpm_from_boot_o <= boot;
        lpm_page_o <= page;
        @(posedge clock_i);
    endtask
endmodule // spfs_core_model

// ### sim/self_program_flash_section_control_bench.sv
// testbench for spfs_ctrl: avalon register tasks, core model, checks
// assumes: 100 MHz clock, synchronous active-high reset, enable dropped once
`timescale 1ns/1ns
`include "spfs_defs.svh"
module self_program_flash_section_control_bench;
    import spfs_pkg::*;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic chip_erase_i = 1'b0;
    logic enable_i = 1'b1;
    logic [4:0] avs_address_i = '0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = '0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o, core_halt_o, rww_block_o, lpm_deny_o, irq_o;
    logic lpm_from_boot_i;
    spfs_store_req_t store_i;
    spfs_page_t lpm_page_i, pg;
    logic [31:0] rd;
    logic [3:0] lk = 4'hF;
    logic [1:0] fz = 2'h0;
    logic [1:0] msk = 2'h3;
    logic [1:0] codes [4] = '{2'b11, 2'b10, 2'b00, 2'b01};
    int n_errors = 0;
    int n_checks = 0;
    always #5 clock_i = ~clock_i;
    spfs_ctrl u_spfs_ctrl (.clock_i(clock_i), .reset_i(reset_i),
        .enable_i(enable_i), .chip_erase_i(chip_erase_i), .store_i(store_i),
        .lpm_from_boot_i(lpm_from_boot_i), .lpm_page_i(lpm_page_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .core_halt_o(core_halt_o),
        .rww_block_o(rww_block_o), .lpm_deny_o(lpm_deny_o), .irq_o(irq_o));
    spfs_core_model u_spfs_core_model (.clock_i(clock_i),
        .halt_i(core_halt_o), .busy_i(rww_block_o), .store_o(store_i),
        .lpm_from_boot_o(lpm_from_boot_i), .lpm_page_o(lpm_page_i));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one avalon transfer; held until the rising edge with waitrequest
    // low, data taken there; a hang is left to the watchdog
    task automatic bus(input logic wr, input logic [4:0] a,
            input logic [31:0] d);
        @(posedge clock_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        do begin
            @(posedge clock_i);
        end while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    // store allowed: from boot, and the owning lock pair's write bit set
    function automatic logic may_prog(input logic boot, input spfs_page_t p);
        logic in_boot;
        in_boot = int'(p) >= (1 << `SPFS_PAGE_W) - (16 >> fz);
        return boot && (in_boot ? lk[2] : lk[0]);
    endfunction
    // store from the core, then follow halt, busy and interrupt state
    task automatic prog(input logic boot, input spfs_page_t p,
            input int frz = 0);
        int h;
        logic b, ok, hs;
        logic [1:0] ev;
        hs = p >= `SPFS_HALTING_SECTION_FIRST;
        ok = may_prog(boot, p);
        ev = ok ? 2'b01 : 2'b10;
        h = 0;
        b = 1'b0;
        u_spfs_core_model.do_store(1'($urandom % 2), boot, p);
        fork
            repeat (`SPFS_PROG_CYC + 20) begin
                @(negedge clock_i);
                h += int'(core_halt_o === 1'b1);
                b |= (rww_block_o === 1'b1);
            end
            // status mid-program: active, halt and busy bits
            begin
                repeat (50) @(negedge clock_i);
                bus(1'b0, `SPFS_REG_STAT, 32'h0);
                check("status run", {29'h0, ok, ok && hs, ok && !hs},
                    rd);
            end
            // frozen cycles stretch the stall by the same count
            if (frz > 0) begin
                repeat (200) @(posedge clock_i);
                enable_i <= 1'b0;
                repeat (frz) @(posedge clock_i);
                enable_i <= 1'b1;
            end
        join
        check("halt cycles", (ok && hs) ? `SPFS_PROG_CYC + frz : 0,
            h);
        check("busy seen", {31'h0, ok && !hs}, {31'h0, b});
        if (ok && !hs) begin
            check("busy held", 32'h1, {31'h0, rww_block_o});
            bus(1'b0, `SPFS_REG_STAT, 32'h0);
            check("status", 32'h1, rd);
            bus(1'b1, `SPFS_REG_CTRL, 32'h4);
            repeat (2) @(negedge clock_i);
            check("busy cleared", 32'h0, {31'h0, rww_block_o});
        end
        // every store raises an event, allowed or not, so read it back
        check("irq line", {31'h0, |(ev & msk)}, {31'h0, irq_o});
        bus(1'b0, `SPFS_REG_IRQS, 32'h0);
        check("irq status", {30'h0, ev}, rd);
        repeat (2) @(negedge clock_i);
        check("irq cleared", 32'h0, {31'h0, irq_o});
    endtask
    task automatic load(input logic boot, input spfs_page_t p, input logic x);
        u_spfs_core_model.do_load(boot, p);
        @(negedge clock_i);
        check("load deny", {31'h0, x}, {31'h0, lpm_deny_o});
    endtask
    task automatic erase_all();
        @(posedge clock_i);
        chip_erase_i <= 1'b1;
        @(posedge clock_i);
        chip_erase_i <= 1'b0;
        lk = 4'hF;
    endtask
    // hang guard, well above the roughly 8300 cycles the run needs
    initial begin
        repeat (40000) @(posedge clock_i);
        n_errors++;
        report_and_stop();
    end
    initial begin
        void'($urandom(99208));
        repeat (20) @(posedge clock_i);
        reset_i <= 1'b0;
        // reset values and an unmapped place
        bus(1'b0, `SPFS_REG_LOCK, 32'h0);
        check("lock reset", 32'hF, rd);
        bus(1'b0, `SPFS_REG_FUSE, 32'h0);
        check("fuse reset", 32'h0, rd);
        bus(1'b1, 5'h18, 32'hFFFFFFFF);
        bus(1'b0, 5'h18, 32'h0);
        check("unmapped", 32'h0, rd);
        bus(1'b1, `SPFS_REG_IRQM, 32'h3);
        // section boundaries first, then random pages and sources
        prog(1'b0, 7'h00);
        prog(1'b1, 7'h6F);
        prog(1'b1, 7'h70, 10);
        prog(1'b1, 7'h7F);
        repeat (6) prog(1'($urandom % 4 != 0), 7'($urandom % 128));
        // every application lock code; each needs a chip erase first
        foreach (codes[i]) begin
            erase_all();
            bus(1'b1, `SPFS_REG_LOCK, {28'h0, 2'b11, codes[i]});
            lk = {2'b11, codes[i]};
            bus(1'b1, `SPFS_REG_LOCK, 32'hF);
            bus(1'b0, `SPFS_REG_LOCK, 32'h0);
            check("lock readback", {28'h0, lk}, rd);
            pg = 7'($urandom % `SPFS_HALTING_SECTION_FIRST);
            load(1'b1, pg, ~codes[i][1]);
            load(1'b0, pg, 1'b0);
            prog(1'b1, pg);
        end
        // boot pair on its own, then a smaller boot section
        erase_all();
        bus(1'b1, `SPFS_REG_LOCK, 32'hB);
        lk = 4'hB;
        prog(1'b1, 7'h7C);
        prog(1'b1, 7'h20);
        bus(1'b1, `SPFS_REG_FUSE, 32'h1);
        fz = 2'h1;
        bus(1'b0, `SPFS_REG_FUSE, 32'h0);
        check("fuse", 32'h1, rd);
        prog(1'b1, 7'h70);
        prog(1'b1, 7'h78);
        // masked events leave the line low
        bus(1'b1, `SPFS_REG_IRQM, 32'h0);
        msk = 2'h0;
        prog(1'b1, 7'h74);
        report_and_stop();
    end
endmodule // self_program_flash_section_control_bench
